// ===== hw/link_regs_pkg.sv
package link_regs_pkg;

  // ==========================================================
  // Register indexes (byte address is four times the index)
  // ==========================================================
  localparam logic [9:0] IDX_CTRL1  = 10'h201;
  localparam logic [9:0] IDX_CTRL2  = 10'h202;
  localparam logic [9:0] IDX_DID    = 10'h203;
  localparam logic [9:0] IDX_CTRL3  = 10'h204;
  localparam logic [9:0] IDX_STATUS = 10'h205;
  localparam logic [9:0] IDX_MISUSE = 10'h280;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] RST_CTRL1  = 8'h0f;
  localparam logic [7:0] RST_CTRL2  = 8'h00;
  localparam logic [7:0] RST_DID    = 8'h00;
  localparam logic [7:0] RST_CTRL3  = 8'h00;

  // ==========================================================
  // Field positions and writable masks
  // ==========================================================
  localparam int SCR_BIT     = 7;
  localparam int KM1_HI      = 6;
  localparam int KM1_LO      = 2;
  localparam int RATE_BIT    = 1;
  localparam int EN_BIT      = 0;
  localparam int P54_BIT     = 7;
  localparam int SYNCSEL_BIT = 6;
  localparam int TEST_HI     = 3;
  localparam int FRAME_END_COMMA_SELECT_HI    = 1;
  localparam int SYNC_ST_BIT = 5;
  localparam logic [7:0] MASK_CTRL2 = 8'hcf;
  localparam logic [7:0] MASK_CTRL3 = 8'h03;

  // ==========================================================
  // Characters and rate codes (rate in quarters of sample clock)
  // ==========================================================
  localparam logic [7:0] CHAR_K28_7 = 8'hfc;
  localparam logic [7:0] CHAR_K28_1 = 8'h3c;
  localparam logic [7:0] CHAR_K28_5 = 8'hbc;
  localparam logic [7:0] CHAR_D21_5 = 8'hb5;
  localparam logic [3:0] RATE_1X    = 4'h4;
  localparam logic [3:0] RATE_2X    = 4'h8;
  localparam logic [3:0] RATE_1P25X = 4'h5;
  localparam logic [3:0] RATE_2P5X  = 4'ha;

  typedef enum logic [3:0] {
    TP_NORMAL   = 4'b0000,
    TP_PRBS7    = 4'b0001,
    TP_PRBS15   = 4'b0010,
    TP_PRBS23   = 4'b0011,
    TP_RAMP     = 4'b0100,
    TP_TRANSP   = 4'b0101,
    TP_D21_5    = 4'b0110,
    TP_K28_5    = 4'b0111,
    TP_ILA_REP  = 4'b1000,
    TP_MOD_RPAT = 4'b1001,
    TP_LOW      = 4'b1010,
    TP_HIGH     = 4'b1011
  } test_mode_t;

  typedef struct packed {
    logic       scrambler_enable;
    logic [4:0] k_minus_1;
    logic       double_rate;
    logic       five_quarter_pll_enable;
    logic       sync_source_select;
    logic [3:0] link_test_pattern;
    logic [7:0] link_device_id;
    logic [1:0] frame_end_comma_select;
  } link_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       is_k;
    logic [7:0] data;
  } lane_char_t;

endpackage

// ===== hw/lane_pattern_gen.sv
`timescale 1ns/10ps
module lane_pattern_gen (
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  input  wire logic                      run,
  input  wire link_regs_pkg::test_mode_t mode,
  output      link_regs_pkg::lane_char_t lane
);
  import link_regs_pkg::*;

  typedef struct packed {
    logic [22:0] prbs;
    logic [7:0]  ramp;
    lane_char_t  lane;
  } gen_state_t;

  gen_state_t s_r;
  gen_state_t s_nxt;
  logic       fb;
  logic [7:0] bits;

  // ==========================================================
  // Pattern step: eight serial bits per cycle
  // ==========================================================
  always_comb begin
    s_nxt = s_r;
    fb    = 1'b0;
    bits  = 8'h00;
    s_nxt.lane = '0;
    for (int i = 7; i >= 0; i--) begin
      case (mode)
        TP_PRBS7:  fb = s_nxt.prbs[6] ^ s_nxt.prbs[5];
        TP_PRBS15: fb = s_nxt.prbs[14] ^ s_nxt.prbs[13];
        default:   fb = s_nxt.prbs[22] ^ s_nxt.prbs[17];
      endcase
      bits[i]    = fb;
      s_nxt.prbs = {s_nxt.prbs[21:0], fb};
    end
    if (mode != TP_PRBS7 && mode != TP_PRBS15 && mode != TP_PRBS23) begin
      s_nxt.prbs = s_r.prbs;
    end
    case (mode)
      TP_PRBS7, TP_PRBS15, TP_PRBS23: begin
        s_nxt.lane = '{valid: 1'b1, is_k: 1'b0, data: bits};
      end
      TP_RAMP: begin
        s_nxt.ramp = s_r.ramp + 8'h01;
        s_nxt.lane = '{valid: 1'b1, is_k: 1'b0, data: s_r.ramp};
      end
      TP_D21_5: s_nxt.lane = '{valid: 1'b1, is_k: 1'b0, data: CHAR_D21_5};
      TP_K28_5: s_nxt.lane = '{valid: 1'b1, is_k: 1'b1, data: CHAR_K28_5};
      TP_LOW:   s_nxt.lane = '{valid: 1'b1, is_k: 1'b0, data: 8'h00};
      TP_HIGH:  s_nxt.lane = '{valid: 1'b1, is_k: 1'b0, data: 8'hff};
      // Framer-built patterns and reserved codes pass the framer through
      default:  s_nxt.lane = '0;
    endcase
    // Idle lane restarts every pattern from its seed
    if (!run) begin
      s_nxt.prbs = '1;
      s_nxt.ramp = 8'h00;
      s_nxt.lane = '0;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_r.prbs <= '1;
      s_r.ramp <= 8'h00;
      s_r.lane <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lane = s_r.lane;

endmodule

// ===== hw/serial_link_control_regs.sv
// How it works
// - Bit 7 of control one enables scrambling
// - Bits 6-2 hold frames per multiframe minus one
// - Bit 1 selects single or double rate
// - Bit 0 enables the link, reset one
// - Disabled link: reset, powered down, clocks gated
// - Five-quarter PLL bit scales the bit rate
// - Sync source bit picks single or differential input
// - Test codes 0-5 select normal and patterns
// - Test codes 6-11 fixed patterns, 12-15 reserved
// - Identifier register feeds the alignment sequence
// - Bits 1-0 select the frame-end comma
// - Transmitter substitutes the comma opportunistically
// - Status bit 5 shows the sync level
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps
module serial_link_control_regs (
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output      logic [31:0]        hrdata,
  output      logic               hreadyout,
  output      logic               hresp,
  input  wire logic               sync_single_ended_input,
  input  wire logic               sync_differential_input,
  output      link_regs_pkg::link_cfg_t  link_cfg,
  output      logic               link_enable,
  output      logic               tx_in_reset,
  output      logic               serializer_power_down,
  output      logic               tx_clock_enable,
  output      logic [3:0]         lane_rate_quarters,
  output      logic [7:0]         frame_end_char,
  output      logic               sync_n,
  output      link_regs_pkg::lane_char_t test_lane
);
  import link_regs_pkg::*;

  // ==========================================================
  // Bus timing
  // ==========================================================
  // No wait states; the answer is always OKAY.
  // The address phase is kept in wr_pend and wr_idx;
  // the write lands at the edge ending the data phase.
  // Reads use the next state, so a read right after a
  // write sees it, at the cost of one logic level.
  // Registers are bytes in hwdata[7:0]; hsize is not
  // decoded, so a narrow write replaces the byte too.
  // Unmapped or misaligned transfers answer OKAY:
  // reads give zero, writes are dropped, nothing stalls.

  typedef struct packed {
    logic [7:0]  ctrl1;
    logic [7:0]  ctrl2;
    logic [7:0]  did;
    logic [7:0]  ctrl3;
    logic        misuse;
    logic        wr_pend;
    logic [9:0]  wr_idx;
    logic [31:0] rdata;
    logic        readyout;
    logic        resp;
    logic [1:0]  se_sync;
    logic [1:0]  diff_sync;
    logic        sync_level;
    logic        tx_reset;
    logic        pwr_down;
    logic        clk_en;
    logic [3:0]  rate;
    logic [7:0]  fe_char;
  } regs_state_t;

  regs_state_t s_r;
  regs_state_t s_nxt;
  logic        sel_addr;
  logic        addr_ok;
  logic        locked;
  logic        misuse_set;
  logic        misuse_clr;
  logic [7:0]  wb;
  logic [7:0]  rd_byte;

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    s_nxt      = s_r;
    misuse_set = 1'b0;
    misuse_clr = 1'b0;
    rd_byte    = 8'h00;
    wb         = hwdata[7:0];
    locked     = s_r.ctrl1[EN_BIT];

    // Locking uses enable as it stood before this write:
    // clearing enable and changing fields in one write
    // is refused for the fields, so clear enable alone.
    // The enable bit is always written, so a locked link
    // can still be switched off. A refused change sets
    // the sticky misuse bit; writing one clears it.
    // Write data phase; a locked field keeps its value
    if (s_r.wr_pend) begin
      case (s_r.wr_idx)
        IDX_CTRL1: begin
          s_nxt.ctrl1[EN_BIT] = wb[EN_BIT];
          if (!locked) begin
            s_nxt.ctrl1 = wb;
          end else if (wb[7:1] != s_r.ctrl1[7:1]) begin
            misuse_set = 1'b1;
          end
        end
        IDX_CTRL2: begin
          if (!locked) begin
            s_nxt.ctrl2 = wb & MASK_CTRL2;
          end else if ((wb & MASK_CTRL2) != s_r.ctrl2) begin
            misuse_set = 1'b1;
          end
        end
        IDX_DID: begin
          if (!locked) begin
            s_nxt.did = wb;
          end else if (wb != s_r.did) begin
            misuse_set = 1'b1;
          end
        end
        IDX_CTRL3: begin
          if (!locked) begin
            s_nxt.ctrl3 = wb & MASK_CTRL3;
          end else if ((wb & MASK_CTRL3) != s_r.ctrl3) begin
            misuse_set = 1'b1;
          end
        end
        IDX_MISUSE: misuse_clr = wb[0];
        default: misuse_clr = 1'b0;
      endcase
    end
    // Set wins, so a misuse is never lost to a clear
    // that software issued a moment too early.
    // A new misuse beats a clear in the same cycle
    s_nxt.misuse = (s_r.misuse & ~misuse_clr) | misuse_set;

    // Both pins are synchronised all the time, so a new
    // source never reads a half-settled flop. Pin to
    // sync_n takes three edges.
    // Sync pins: two flops each, then the source select
    s_nxt.se_sync   = {s_r.se_sync[0], sync_single_ended_input};
    s_nxt.diff_sync = {s_r.diff_sync[0], sync_differential_input};
    s_nxt.sync_level = s_r.ctrl2[SYNCSEL_BIT] ? s_r.diff_sync[1]
                                               : s_r.se_sync[1];

    // Controls follow the next enable value, so they move
    // on the same edge as the register, never later.
    // disabled link held in reset, gated
    s_nxt.tx_reset = ~s_nxt.ctrl1[EN_BIT];
    s_nxt.pwr_down = ~s_nxt.ctrl1[EN_BIT];
    s_nxt.clk_en   = s_nxt.ctrl1[EN_BIT];

    // Rate counts quarters of the sample clock so the
    // five-quarter step stays whole: 4, 8, 5 or 10.
    // base rate; five-quarter scaling
    case ({s_nxt.ctrl2[P54_BIT], s_nxt.ctrl1[RATE_BIT]})
      2'b00:   s_nxt.rate = RATE_1X;
      2'b01:   s_nxt.rate = RATE_2X;
      2'b10:   s_nxt.rate = RATE_1P25X;
      default: s_nxt.rate = RATE_2P5X;
    endcase

    // frame-end comma choice; code 3 falls back to compliant
    case (s_nxt.ctrl3[FRAME_END_COMMA_SELECT_HI:0])
      2'b01:   s_nxt.fe_char = CHAR_K28_1;
      2'b10:   s_nxt.fe_char = CHAR_K28_5;
      default: s_nxt.fe_char = CHAR_K28_7;
    endcase

    // Only NONSEQ and SEQ count; IDLE and BUSY are ignored.
    // Address phase: zero wait states, reads see this cycle's write
    sel_addr = hsel & htrans[1] & hready;
    addr_ok  = (haddr[31:12] == 20'h00000) & (haddr[1:0] == 2'b00);
    s_nxt.wr_pend = sel_addr & hwrite & addr_ok;
    s_nxt.wr_idx  = haddr[11:2];
    case (haddr[11:2])
      IDX_CTRL1:  rd_byte = s_nxt.ctrl1;
      IDX_CTRL2:  rd_byte = s_nxt.ctrl2;
      IDX_DID:    rd_byte = s_nxt.did;
      IDX_CTRL3:  rd_byte = s_nxt.ctrl3;
      // sync level in status bit 5
      IDX_STATUS: rd_byte = {2'b00, s_r.sync_level, 5'b00000};
      IDX_MISUSE: rd_byte = {7'h00, s_nxt.misuse};
      default:    rd_byte = 8'h00;
    endcase
    // Unmapped or misaligned reads return zero, still OKAY
    if (sel_addr & ~hwrite & addr_ok) begin
      s_nxt.rdata = {24'h000000, rd_byte};
    end else begin
      s_nxt.rdata = 32'h00000000;
    end
    s_nxt.readyout = 1'b1;
    s_nxt.resp     = 1'b0;
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Synchronous reset to the reset values; the sync flops
  // start deasserted so no false sync is reported, and
  // the bus answers from the first edge after release.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_r.ctrl1      <= RST_CTRL1;
      s_r.ctrl2      <= RST_CTRL2;
      s_r.did        <= RST_DID;
      s_r.ctrl3      <= RST_CTRL3;
      s_r.misuse     <= 1'b0;
      s_r.wr_pend    <= 1'b0;
      s_r.wr_idx     <= 10'h000;
      s_r.rdata      <= 32'h00000000;
      s_r.readyout   <= 1'b1;
      s_r.resp       <= 1'b0;
      s_r.se_sync    <= 2'b11;
      s_r.diff_sync  <= 2'b11;
      s_r.sync_level <= 1'b1;
      s_r.tx_reset   <= 1'b0;
      s_r.pwr_down   <= 1'b0;
      s_r.clk_en     <= 1'b1;
      s_r.rate       <= RATE_2X;
      s_r.fe_char    <= CHAR_K28_7;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  // ==========================================================
  // Plain wires from s_r flops, so no port glitches while
  // the bus decodes; link_enable and tx_clock_enable
  // share one flop on purpose.
  assign hrdata    = s_r.rdata;
  assign hreadyout = s_r.readyout;
  assign hresp     = s_r.resp;
  assign link_cfg.scrambler_enable        = s_r.ctrl1[SCR_BIT];
  assign link_cfg.k_minus_1               = s_r.ctrl1[KM1_HI:KM1_LO];
  assign link_cfg.double_rate             = s_r.ctrl1[RATE_BIT];
  assign link_cfg.five_quarter_pll_enable = s_r.ctrl2[P54_BIT];
  assign link_cfg.sync_source_select      = s_r.ctrl2[SYNCSEL_BIT];
  assign link_cfg.link_test_pattern       = s_r.ctrl2[TEST_HI:0];
  assign link_cfg.link_device_id          = s_r.did;
  assign link_cfg.frame_end_comma_select  = s_r.ctrl3[FRAME_END_COMMA_SELECT_HI:0];
  assign link_enable           = s_r.clk_en;
  assign tx_in_reset           = s_r.tx_reset;
  assign serializer_power_down = s_r.pwr_down;
  assign tx_clock_enable       = s_r.clk_en;
  assign lane_rate_quarters    = s_r.rate;
  // comma handed to the framer for substitution
  assign frame_end_char        = s_r.fe_char;
  assign sync_n                = s_r.sync_level;

  // ==========================================================
  // Test pattern source, idle while the link is disabled
  // ==========================================================
  // With the link off the source reloads its seed, so
  // every enable starts the same sequence. Framer-built
  // modes and reserved codes leave test_lane idle here.
  // patterns run while enabled
  lane_pattern_gen u_pattern (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .run     (s_r.clk_en),
    .mode    (test_mode_t'(s_r.ctrl2[TEST_HI:0])),
    .lane    (test_lane)
  );

  // ==========================================================
  // Limitations
  // ==========================================================
  // Legal frames counts depend on decimation and rate,
  // which this block cannot see; any value is stored.
  // The decimation field lives elsewhere and is not
  // locked here. Only status bit 5 is live.
  // The misuse bit is a debug aid, not an interrupt.
  // hreadyout and hresp are constant flops; the bus is
  // never stalled or refused by this block.

endmodule

// ===== verification/link_regs_checker.sv
`timescale 1ns/10ps
// ==========================================================
// Output and bus checks on the register block's ports
module link_regs_checker (
  input wire logic                      ref_clk,
  input wire logic                      nrst,
  input wire logic                      hsel,
  input wire logic [31:0]               haddr,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic                      hready,
  input wire logic [31:0]               hrdata,
  input wire logic                      sync_single_ended_input,
  input wire logic                      sync_differential_input,
  input wire link_regs_pkg::link_cfg_t  link_cfg,
  input wire logic                      link_enable,
  input wire logic                      tx_in_reset,
  input wire logic                      serializer_power_down,
  input wire logic                      tx_clock_enable,
  input wire logic [3:0]                lane_rate_quarters,
  input wire logic [7:0]                frame_end_char,
  input wire logic                      sync_n,
  input wire link_regs_pkg::lane_char_t test_lane
);
  import link_regs_pkg::*;
  logic picked_pin;
  logic status_read;

  // Pin that should drive sync, and a status read in address phase
  assign picked_pin = link_cfg.sync_source_select ?
                      sync_differential_input : sync_single_ended_input;
  assign status_read = hsel && htrans[1] && hready && !hwrite &&
                       haddr == {20'h0, IDX_STATUS, 2'b00};

  default clocking dck @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_reset_follows_en: assert property (
    tx_in_reset == !link_enable)
    else $error("transmitter reset does not follow link enable");
  a_power_clock_gate: assert property (
    serializer_power_down == !link_enable && tx_clock_enable == link_enable)
    else $error("power down or clock gate disagrees with enable");
  // Outputs move on the same edge as the fields; the check still waits for two stable
  a_rate_from_cfg: assert property (
    $stable(link_cfg) [*2] |-> lane_rate_quarters ==
      (link_cfg.double_rate ?
        (link_cfg.five_quarter_pll_enable ? RATE_2P5X : RATE_2X) :
        (link_cfg.five_quarter_pll_enable ? RATE_1P25X : RATE_1X)))
    else $error("lane rate does not match rate fields");
  a_comma_choice: assert property (
    $stable(link_cfg) [*2] |-> frame_end_char ==
      (link_cfg.frame_end_comma_select == 2'h1 ? CHAR_K28_1 :
       link_cfg.frame_end_comma_select == 2'h2 ? CHAR_K28_5 : CHAR_K28_7))
    else $error("frame end character does not match its select");
  a_k28_stream: assert property (
    (link_enable && link_cfg.link_test_pattern == TP_K28_5) [*4] |->
      test_lane.valid && test_lane.is_k && test_lane.data == CHAR_K28_5)
    else $error("control character pattern missing");
  a_disabled_quiet: assert property (
    (!link_enable) [*3] |-> !test_lane.valid)
    else $error("test lane active while link disabled");
  a_locked_fields: assert property (
    link_enable [*3] |-> $stable(link_cfg))
    else $error("locked field changed while link enabled");
  a_sync_follows: assert property (
    ($stable(picked_pin) && $stable(link_cfg.sync_source_select)) [*5]
      |-> sync_n == picked_pin)
    else $error("sync level does not follow selected pin");
  a_status_sync: assert property (
    status_read |=> hrdata[5] == $past(sync_n))
    else $error("status read does not show sync level");
endmodule

bind serial_link_control_regs link_regs_checker chk (
  .ref_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .sync_single_ended_input, .sync_differential_input, .link_cfg,
  .link_enable, .tx_in_reset, .serializer_power_down, .tx_clock_enable,
  .lane_rate_quarters, .frame_end_char, .sync_n, .test_lane
);

// ===== verification/link_receiver_model.sv
`timescale 1ns/10ps
// ==========================================================
// Far-end receiver: raises sync on request after lag cycles
module link_receiver_model (
  input  wire logic       ref_clk,
  input  wire logic       want_sync,
  input  wire logic [3:0] lag,
  output      logic       sync_single_ended_input,
  output      logic       sync_differential_input
);
  // pins opposite, so a wrong select is seen; one driver process
  initial begin
    sync_single_ended_input = 1'b1;
    sync_differential_input = 1'b0;
    forever begin
      @(want_sync);
      repeat (lag) @(posedge ref_clk);
      sync_single_ended_input <= !want_sync;
      sync_differential_input <= want_sync;
    end
  end
endmodule

// ===== verification/serial_link_control_regs_tb.sv
`timescale 1ns/10ps
module serial_link_control_regs_tb;
  import link_regs_pkg::*;
  logic                     ref_clk, nrst, hsel, hwrite, hready;
  logic                     hreadyout, hresp, se_pin, diff_pin;
  logic                     want_sync, link_enable, tx_in_reset;
  logic                     serializer_power_down, tx_clock_enable;
  logic                     sync_n;
  logic [31:0]              haddr, hwdata, hrdata;
  logic [1:0]               htrans;
  logic [2:0]               hsize;
  logic [3:0]               lag, lane_rate_quarters;
  logic [7:0]               frame_end_char;
  link_cfg_t                link_cfg;
  lane_char_t               test_lane;
  int                       err_count, total_checks;
  logic [7:0]               comma [4] = '{CHAR_K28_7, CHAR_K28_1,
                                          CHAR_K28_5, CHAR_K28_7};

  assign hready = hreadyout;

  serial_link_control_regs DUT (
    .ref_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp,
    .sync_single_ended_input(se_pin), .sync_differential_input(diff_pin),
    .link_cfg, .link_enable, .tx_in_reset, .serializer_power_down,
    .tx_clock_enable, .lane_rate_quarters, .frame_end_char, .sync_n,
    .test_lane
  );

  link_receiver_model far_end (
    .ref_clk, .want_sync, .lag,
    .sync_single_ended_input(se_pin), .sync_differential_input(diff_pin)
  );

  // ==========================================================
  // Bus and compare helpers
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One single transfer; waits on hready in both phases
  task automatic bus(logic [9:0] idx, logic wr, logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h0, idx, 2'b00};
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(logic [9:0] idx, logic [31:0] d);
    logic [31:0] unused;
    bus(idx, 1'b1, d, unused);
  endtask

  task automatic rd_chk(string name, logic [9:0] idx, logic [31:0] exp);
    logic [31:0] v;
    bus(idx, 1'b0, 32'h0, v);
    check(name, v, exp);
  endtask

  task automatic settle;
    repeat (3) @(posedge ref_clk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd_chk("ctrl1", IDX_CTRL1, 32'(RST_CTRL1));
    rd_chk("ctrl2", IDX_CTRL2, 32'(RST_CTRL2));
    rd_chk("did", IDX_DID, 32'(RST_DID));
    rd_chk("ctrl3", IDX_CTRL3, 32'(RST_CTRL3));
    rd_chk("unmapped", 10'h240, 32'h0);
    check("rate", lane_rate_quarters, RATE_2X);
    check("enable", link_enable, 1'b1);
    check("hresp", hresp, 1'b0);
    $display("test reset done");
  endtask

  // Writes to locked fields while enabled must leave them alone
  task automatic t_lock;
    wr(IDX_CTRL2, 32'h07);
    wr(IDX_DID, 32'h5a);
    wr(IDX_CTRL1, 32'h8f);
    rd_chk("ctrl2 locked", IDX_CTRL2, 32'h0);
    rd_chk("did locked", IDX_DID, 32'h0);
    rd_chk("ctrl1 locked", IDX_CTRL1, 32'h0f);
    rd_chk("misuse set", IDX_MISUSE, 32'h1);
    wr(IDX_MISUSE, 32'h1);
    rd_chk("misuse clear", IDX_MISUSE, 32'h0);
    $display("test lock done");
  endtask

  // no decimation writes are made here
  task automatic t_fields;
    wr(IDX_CTRL1, 32'h0e);
    settle;
    check("tx reset", tx_in_reset, 1'b1);
    check("power down", serializer_power_down, 1'b1);
    check("clock gate", tx_clock_enable, 1'b0);
    wr(IDX_CTRL1, 32'h9c);
    wr(IDX_CTRL2, 32'h80);
    wr(IDX_DID, 32'ha5);
    settle;
    rd_chk("ctrl1 rw", IDX_CTRL1, 32'h9c);
    check("scrambler", link_cfg.scrambler_enable, 1'b1);
    check("k minus one", link_cfg.k_minus_1, 5'd7);
    check("sdr field", link_cfg.double_rate, 1'b0);
    check("pll field", link_cfg.five_quarter_pll_enable, 1'b1);
    check("rate pll sdr", lane_rate_quarters, RATE_1P25X);
    check("device id", link_cfg.link_device_id, 8'ha5);
    wr(IDX_CTRL1, 32'h9e);
    settle;
    check("rate pll ddr", lane_rate_quarters, RATE_2P5X);
    wr(IDX_CTRL2, 32'hff);
    rd_chk("ctrl2 mask", IDX_CTRL2, 32'(MASK_CTRL2));
    wr(IDX_CTRL2, 32'h00);
    settle;
    check("rate ddr", lane_rate_quarters, RATE_2X);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CTRL3, 32'(i));
      settle;
      check("comma", frame_end_char, comma[i]);
      check("comma sel", link_cfg.frame_end_comma_select, 32'(i));
    end
    wr(IDX_CTRL3, 32'h0);
    settle;
    check("comma std", frame_end_char, CHAR_K28_7);
    $display("test fields done");
  endtask

  // Partner answers slowly first, then promptly
  task automatic t_sync;
    wr(IDX_CTRL2, 32'h00);
    repeat (8) @(posedge ref_clk);
    check("sync single", sync_n, 1'b1);
    rd_chk("status high", IDX_STATUS, 32'h20);
    wr(IDX_CTRL2, 32'h40);
    repeat (8) @(posedge ref_clk);
    check("sync diff", sync_n, 1'b0);
    rd_chk("status low", IDX_STATUS, 32'h0);
    check("sync sel", link_cfg.sync_source_select, 1'b1);
    lag <= 4'd9;
    want_sync <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check("sync not yet", sync_n, 1'b0);
    repeat (12) @(posedge ref_clk);
    check("sync slow", sync_n, 1'b1);
    lag <= 4'd0;
    want_sync <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check("sync prompt", sync_n, 1'b0);
    $display("test sync done");
  endtask

  // Test codes 0 to 11, with the link cycled around each change
  task automatic t_patterns;
    logic [7:0] d;
    for (int m = 0; m < 12; m++) begin
      wr(IDX_CTRL1, 32'h0e);
      wr(IDX_CTRL2, 32'(m));
      wr(IDX_CTRL1, 32'h0f);
      settle;
      check("test code", link_cfg.link_test_pattern, 32'(m));
      check("lane valid", test_lane.valid,
            (m == 0 || m == 5 || m == 8 || m == 9) ? 1'b0 : 1'b1);
      if (m == 6)
        check("d21.5", {test_lane.is_k, test_lane.data},
              {1'b0, CHAR_D21_5});
      if (m == 7)
        check("k28.5", {test_lane.is_k, test_lane.data},
              {1'b1, CHAR_K28_5});
      if (m >= 10)
        check("level", test_lane.data, (m == 10) ? 32'h00 : 32'hff);
      if (m == 4) begin
        d = test_lane.data;
        @(posedge ref_clk);
        check("ramp step", test_lane.data, 32'(d + 8'h01));
      end
    end
    $display("test patterns done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // Clock, reset, sequence and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = !ref_clk;
  end

  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    want_sync = 1'b0;
    lag = 4'd0;
    err_count = 0;
    total_checks = 0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset;
    t_lock;
    t_fields;
    t_sync;
    t_patterns;
    give_verdict;
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #500000;
    err_count++;
    give_verdict;
  end
endmodule
